/* File: verilog/cpa_pkg.sv */
// constants, states and pin carriers for the channel priority arbiter
package cpa_pkg;

    // ======================================================================
    // timing
    localparam int CLK_PERIOD_NS  = 50;    // core_clk at 20 MHz
    localparam int TMR_W          = 8;
    localparam int RELEASE_MAX_NS = 7800;  // channel_request_n to channel release
    localparam int EXIT_DELAY_NS  = 100;   // inactive exit alternate delay
    localparam int ABORT_PULSE_NS = 85;    // aborted cycle status width
    localparam int BURST_MAX_NS   = 50;    // grant to burst line active
    localparam int STAT_NS        = 100;   // status phase of a cycle
    localparam int CMD_NS         = 100;   // command phase of a cycle

    // longest times round down, least times round up, never below one
    localparam int RELEASE_MAX_CYC = RELEASE_MAX_NS / CLK_PERIOD_NS;
    localparam logic [TMR_W-1:0] EXIT_CNT =
        TMR_W'((EXIT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] ABORT_CNT =
        TMR_W'((ABORT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam int BURST_MAX_CYC =
        (BURST_MAX_NS / CLK_PERIOD_NS) < 1 ? 1 : BURST_MAX_NS / CLK_PERIOD_NS;
    localparam logic [TMR_W-1:0] STAT_CNT =
        TMR_W'((STAT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [TMR_W-1:0] CMD_CNT =
        TMR_W'((CMD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);

    // ======================================================================
    // arbitration encodings
    localparam int         LEVEL_W       = 4;
    localparam logic [3:0] LEVEL_DEFAULT = 4'hF;  // default master level
    localparam logic       GP_ARB        = 1'b1;  // grant_phase arbitrate
    localparam logic       GP_GNT        = 1'b0;  // grant_phase grant

    // ======================================================================
    // states
    typedef enum logic [3:0] {
        CPA_IDLE     = 4'h0,
        CPA_WAIT     = 4'h1,
        CPA_COMPETE  = 4'h2,
        CPA_OWN      = 4'h3,
        CPA_ABORT    = 4'h4,
        CPA_END      = 4'h5,
        CPA_INACTIVE = 4'h6,
        CPA_EXIT     = 4'h7
    } cpa_state_e;

    typedef enum logic [1:0] {
        CPA_PH_NONE = 2'h0,
        CPA_PH_STAT = 2'h1,
        CPA_PH_CMD  = 2'h2
    } cpa_phase_e;

    // ======================================================================
    // pin carriers; every line except grant_phase is active low and released when not driven
    typedef struct packed {
        logic       grant_phase;
        logic       channel_request_n;
        logic       burst_n;
        logic       status0_n;
        logic       status1_n;
        logic       cmd_n;
        logic [3:0] priority_lines;
    } cpa_pins_in_s;

    typedef struct packed {
        logic       channel_request_n;
        logic       burst_n;
        logic       status0_n;
        logic       status1_n;
        logic       cmd_n;
        logic       address_latch_n;
        logic [3:0] priority_lines;
    } cpa_pins_drv_s;

endpackage : cpa_pkg

/* File: verilog/cpa_lane.sv */
// bit-serial priority compare and open-collector drive of the level lines
`timescale 1ns/1ps
module cpa_lane #(
    parameter int LEVEL_W = 4
) (
    input  wire logic               core_clk,
    input  wire logic               resetn,
    input  wire logic               en,
    input  wire logic [LEVEL_W-1:0] level,
    input  wire logic [LEVEL_W-1:0] bus,
    output logic      [LEVEL_W-1:0] drive_oe,
    output logic                    match
);
    // ======================================================================
    // elaboration check
    if (LEVEL_W < 1 || LEVEL_W > 8)
    begin : g_bad_width
        $error("cpa_lane: LEVEL_W out of range");
    end

    // ======================================================================
    // agreement chain from the top line down
    wire logic [LEVEL_W:0] ok;
    assign ok[LEVEL_W] = 1'b1;

    // a line is pulled low for a zero bit only while all higher lines agree
    for (genvar i = 0; i < LEVEL_W; i++)
    begin : g_bit
        assign ok[i]       = ok[i+1] & (bus[i] == level[i]);
        assign drive_oe[i] = en & ok[i+1] & ~level[i];
    end

    assign match = ok[0];

    // ======================================================================
    // checks
    chk_lane_cut_low: assert property (@(posedge core_clk)
        disable iff (!resetn)
        (bus[LEVEL_W-1] != level[LEVEL_W-1]) |->
            (drive_oe[LEVEL_W-2:0] == '0))
        else $error("lower lines driven after top-line mismatch");

    chk_lane_idle_off: assert property (@(posedge core_clk)
        disable iff (!resetn)
        !en |-> (drive_oe == '0))
        else $error("level lines driven while not competing");

endmodule : cpa_lane

/* File: verilog/cpa_arbiter.sv */
// local arbiter and channel owner sequencer for one arbitrating participant
//
// Notes on behaviour
// - four level lines give sixteen levels; zero wins, F loses.
// - join a cycle only if requesting before the cycle starts.
// - control point opens a cycle by arbitrate state; competitors drive.
// - compare from top line; mismatch stops lower lines until match.
// - lowest level presented owns channel when grant state returns.
// - won indication is false while grant_phase is arbitrate.
// - burst line held until transfers done or another requests.
// - burst line only after grant, held past start of last cycle.
// - on another request, release and end transfer within 7.8 us.
// - in arbitrate state only request and level lines stay driven.
// - new owner starts a cycle; abort is a bare status pulse.
// - drop the request line once ownership is gained.
// - bursting participants have a fairness enable bit.
// - release even without fairness; fairness adds inactive state.
// - inactive participant neither requests nor arbitrates.
// - leave inactive after request idle, then status edge or delay.
// - alternate exit delay is at least 100 ns.
// - aborted cycle status pulse is at least 85 ns wide.
// - burst line active within 50 ns of grant.
`timescale 1ns/1ps
module cpa_arbiter #(
    parameter int LEVEL_W = cpa_pkg::LEVEL_W
) (
    input  wire logic                  core_clk,
    input  wire logic                  resetn,
    input  wire logic                  req,
    input  wire logic [LEVEL_W-1:0]    arb_level,
    input  wire logic                  burst_mode,
    input  wire logic                  fairness_en,
    input  wire logic                  abort_first,
    input  wire logic                  xfer_go,
    input  wire logic                  xfer_last,
    input  wire cpa_pkg::cpa_pins_in_s pins_in,
    output cpa_pkg::cpa_pins_drv_s     pins_out,
    output cpa_pkg::cpa_pins_drv_s     pins_oe,
    output logic                       arbitration_won,
    output logic                       xfer_busy,
    output logic                       inactive,
    output logic                       channel_request_n_seen
);
    // ======================================================================
    // elaboration check
    if (LEVEL_W != cpa_pkg::LEVEL_W)
    begin : g_bad_width
        $error("cpa_arbiter: level width must match the pin carrier");
    end

    // ======================================================================
    // decoding used in several places
    function automatic logic is_owner(input cpa_pkg::cpa_state_e s);
        is_owner = (s == cpa_pkg::CPA_OWN) || (s == cpa_pkg::CPA_ABORT);
    endfunction : is_owner

    // ======================================================================
    // pin synchronisers
    cpa_pkg::cpa_pins_in_s sync1_r;
    cpa_pkg::cpa_pins_in_s sync2_r;
    logic                  stat_prev_r;
    wire logic stat_any  = ~sync2_r.status0_n | ~sync2_r.status1_n;

    // two stages before any logic looks at a pin
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            sync1_r     <= '1;
            sync2_r     <= '1;
            stat_prev_r <= 1'b0;
        end
        else
        begin
            sync1_r     <= pins_in;
            sync2_r     <= sync1_r;
            stat_prev_r <= stat_any;
        end
    end

    // ======================================================================
    // state
    cpa_pkg::cpa_state_e state_r,   state_nxt;
    cpa_pkg::cpa_phase_e phase_r,   phase_nxt;
    logic [cpa_pkg::TMR_W-1:0] cnt_r,   cnt_nxt;
    logic [cpa_pkg::TMR_W-1:0] tmr_r,   tmr_nxt;
    logic                saw_gnt_r, saw_gnt_nxt;
    logic                channel_request_n_r, channel_request_n_nxt;
    logic                last_r,    last_nxt;
    logic                first_r,   first_nxt;
    logic                burst_r,   burst_nxt;
    logic [2:0]          req_hist_r;

    // ======================================================================
    // decoded pin views
    wire logic gp_arb    = (sync2_r.grant_phase == cpa_pkg::GP_ARB);
    wire logic stat_fall = stat_prev_r & ~stat_any;   // status trailing edge
    wire logic req_drv   = (state_r == cpa_pkg::CPA_WAIT) ||
                           (state_r == cpa_pkg::CPA_COMPETE);
    // a low request line that our own recent drive cannot explain
    wire logic other_req = ~sync2_r.channel_request_n &
                           ~req_drv & ~(|req_hist_r);
    wire logic compete   = (state_r == cpa_pkg::CPA_COMPETE) & gp_arb;
    wire logic own       = is_owner(state_r);
    wire logic cnt_done  = (cnt_r == cpa_pkg::TMR_W'(1));
    wire logic [LEVEL_W-1:0] lane_oe;
    wire logic               lane_match;

    // ======================================================================
    // local arbiter lane
    cpa_lane #(
        .LEVEL_W (LEVEL_W)
    ) u_lane (
        .core_clk (core_clk),
        .resetn   (resetn),
        .en       (compete),
        .level    (arb_level),
        .bus      (sync2_r.priority_lines),
        .drive_oe (lane_oe),
        .match    (lane_match)
    );

    // ======================================================================
    // next-state logic
    always_comb
    begin
        state_nxt   = state_r;
        phase_nxt   = phase_r;
        cnt_nxt     = cnt_r;
        saw_gnt_nxt = saw_gnt_r;
        channel_request_n_nxt = channel_request_n_r | (own & other_req);
        last_nxt    = last_r;
        first_nxt   = first_r;
        burst_nxt   = burst_r;
        tmr_nxt     = (own && channel_request_n_r) ? tmr_r + 1'b1 : '0;
        unique case (state_r)
            cpa_pkg::CPA_IDLE:
            begin
                if (req)
                begin
                    state_nxt   = cpa_pkg::CPA_WAIT;
                    saw_gnt_nxt = ~gp_arb;
                end
            end
            cpa_pkg::CPA_WAIT:
            begin
                if (!req)
                    state_nxt = cpa_pkg::CPA_IDLE;
                else if (!gp_arb)
                    saw_gnt_nxt = 1'b1;
                else if (saw_gnt_r)
                    state_nxt = cpa_pkg::CPA_COMPETE;
            end
            cpa_pkg::CPA_COMPETE:
            begin
                if (!gp_arb)
                begin
                    if (lane_match)
                    begin
                        state_nxt   = cpa_pkg::CPA_OWN;
                        burst_nxt   = burst_mode;
                        first_nxt   = 1'b1;
                        channel_request_n_nxt = 1'b0;
                        last_nxt    = ~burst_mode;
                        phase_nxt   = cpa_pkg::CPA_PH_NONE;
                    end
                    else
                    begin
                        state_nxt   = cpa_pkg::CPA_WAIT;
                        saw_gnt_nxt = 1'b1;
                    end
                end
            end
            cpa_pkg::CPA_OWN:
            begin
                if (gp_arb)
                begin
                    // channel taken back by the control point
                    state_nxt = cpa_pkg::CPA_END;
                    burst_nxt = 1'b0;
                    phase_nxt = cpa_pkg::CPA_PH_NONE;
                end
                else if (phase_r == cpa_pkg::CPA_PH_NONE)
                begin
                    if (first_r && abort_first)
                    begin
                        state_nxt = cpa_pkg::CPA_ABORT;
                        cnt_nxt   = cpa_pkg::ABORT_CNT;
                        burst_nxt = 1'b0;
                    end
                    else if (xfer_go)
                    begin
                        phase_nxt = cpa_pkg::CPA_PH_STAT;
                        cnt_nxt   = cpa_pkg::STAT_CNT;
                        first_nxt = 1'b0;
                        last_nxt  = last_r | xfer_last | channel_request_n_r;
                    end
                    else if (channel_request_n_r || (last_r && !first_r))
                    begin
                        state_nxt = cpa_pkg::CPA_END;
                        burst_nxt = 1'b0;
                    end
                end
                else if (cnt_done)
                begin
                    if (phase_r == cpa_pkg::CPA_PH_STAT)
                    begin
                        phase_nxt = cpa_pkg::CPA_PH_CMD;
                        cnt_nxt   = cpa_pkg::CMD_CNT;
                        if (last_r)
                            burst_nxt = 1'b0;
                    end
                    else
                    begin
                        phase_nxt = cpa_pkg::CPA_PH_NONE;
                        if (last_r)
                        begin
                            state_nxt = cpa_pkg::CPA_END;
                            burst_nxt = 1'b0;
                        end
                    end
                end
                else
                    cnt_nxt = cnt_r - 1'b1;
            end
            cpa_pkg::CPA_ABORT:
            begin
                if (cnt_done)
                    state_nxt = cpa_pkg::CPA_END;
                else
                    cnt_nxt = cnt_r - 1'b1;
            end
            cpa_pkg::CPA_END:
            begin
                // hold end of transfer until the next cycle opens
                if (gp_arb)
                    state_nxt = (fairness_en && channel_request_n_r) ?
                                cpa_pkg::CPA_INACTIVE : cpa_pkg::CPA_IDLE;
            end
            cpa_pkg::CPA_INACTIVE:
            begin
                if (sync2_r.channel_request_n)
                begin
                    state_nxt = cpa_pkg::CPA_EXIT;
                    cnt_nxt   = cpa_pkg::EXIT_CNT;
                end
            end
            cpa_pkg::CPA_EXIT:
            begin
                if (stat_fall || cnt_done)
                    state_nxt = cpa_pkg::CPA_IDLE;
                else
                    cnt_nxt = cnt_r - 1'b1;
            end
            default:
                state_nxt = cpa_pkg::CPA_IDLE;
        endcase
    end

    // ======================================================================
    // state registers
    always_ff @(posedge core_clk)
    begin
        if (!resetn)
        begin
            state_r    <= cpa_pkg::CPA_IDLE;
            phase_r    <= cpa_pkg::CPA_PH_NONE;
            cnt_r      <= '0;
            tmr_r      <= '0;
            saw_gnt_r  <= 1'b0;
            channel_request_n_r  <= 1'b0;
            last_r     <= 1'b0;
            first_r    <= 1'b0;
            burst_r    <= 1'b0;
            req_hist_r <= '0;
        end
        else
        begin
            state_r    <= state_nxt;
            phase_r    <= phase_nxt;
            cnt_r      <= cnt_nxt;
            tmr_r      <= tmr_nxt;
            saw_gnt_r  <= saw_gnt_nxt;
            channel_request_n_r  <= channel_request_n_nxt;
            last_r     <= last_nxt;
            first_r    <= first_nxt;
            burst_r    <= burst_nxt;
            req_hist_r <= {req_hist_r[1:0], req_drv};
        end
    end

    // ======================================================================
    // pin drive: every line is pulled low when enabled
    wire logic stat_oe = (state_r == cpa_pkg::CPA_ABORT) ||
                         (state_r == cpa_pkg::CPA_OWN &&
                          phase_r == cpa_pkg::CPA_PH_STAT);
    wire logic cmd_oe  = (state_r == cpa_pkg::CPA_OWN) &&
                         (phase_r == cpa_pkg::CPA_PH_CMD);

    assign pins_out = '0;
    assign pins_oe.channel_request_n = req_drv;
    assign pins_oe.burst_n           = burst_r & own;
    assign pins_oe.status0_n         = stat_oe;
    assign pins_oe.status1_n         = stat_oe;
    assign pins_oe.cmd_n             = cmd_oe;
    assign pins_oe.address_latch_n   = stat_oe &
                                       (state_r != cpa_pkg::CPA_ABORT);
    assign pins_oe.priority_lines    = lane_oe;

    // ======================================================================
    // user-side status
    assign arbitration_won = own & ~gp_arb;
    assign xfer_busy       = own & (phase_r != cpa_pkg::CPA_PH_NONE);
    assign inactive        = (state_r == cpa_pkg::CPA_INACTIVE) ||
                             (state_r == cpa_pkg::CPA_EXIT);
    assign channel_request_n_seen    = channel_request_n_r;

    // ======================================================================
    // checks
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!resetn);

    chk_won_not_arb: assert property (gp_arb |-> !arbitration_won)
        else $error("won indication during arbitrate state");

    chk_owner_level: assert property (
        $rose(state_r == cpa_pkg::CPA_OWN) |->
            $past(sync2_r.priority_lines) == arb_level && !gp_arb)
        else $error("ownership taken without matching level");

    chk_req_dropped: assert property (
        $rose(own) |-> !pins_oe.channel_request_n)
        else $error("request still driven after winning");

    chk_burst_soon: assert property (
        ($rose(state_r == cpa_pkg::CPA_OWN) && burst_mode) |->
            pins_oe.burst_n)
        else $error("burst line late after grant");

    chk_abort_pulse: assert property (
        $rose(state_r == cpa_pkg::CPA_ABORT) |->
            (pins_oe.status0_n && !pins_oe.cmd_n &&
             !pins_oe.address_latch_n)[*2])
        else $error("aborted status pulse too short or has command");

    chk_release_limit: assert property (
        own |-> tmr_r < cpa_pkg::TMR_W'(cpa_pkg::RELEASE_MAX_CYC))
        else $error("channel held too long after preemption");

    chk_quiet_arb: assert property (
        (gp_arb && !own) |->
            !(pins_oe.burst_n || stat_oe || cmd_oe))
        else $error("channel drivers on during arbitrate state");

    chk_inactive_quiet: assert property (
        inactive |-> !pins_oe.channel_request_n &&
                     pins_oe.priority_lines == '0)
        else $error("inactive participant requesting or competing");

    chk_fair_inactive: assert property (
        (state_r == cpa_pkg::CPA_END && gp_arb && fairness_en &&
         channel_request_n_r) |=> state_r == cpa_pkg::CPA_INACTIVE)
        else $error("fairness did not enter the inactive state");

    chk_join_late: assert property (
        $rose(state_r == cpa_pkg::CPA_COMPETE) |-> $past(saw_gnt_r))
        else $error("competed in a cycle already under way");

    cov_won: cover property ($rose(state_r == cpa_pkg::CPA_OWN));
    cov_abort: cover property ($rose(state_r == cpa_pkg::CPA_ABORT));
    cov_channel_request_n: cover property ($rose(channel_request_n_r) ##[1:40]
                                 state_r == cpa_pkg::CPA_END);
    cov_inactive_exit: cover property (
        state_r == cpa_pkg::CPA_EXIT ##1 state_r == cpa_pkg::CPA_IDLE);

endmodule : cpa_arbiter

/* File: test/cpa_bus_model.sv */
// control point, default master and one rival for the local arbiter
`timescale 1ns/1ps
module cpa_bus_model (
    input  wire logic                   core_clk,
    input  wire logic                   resetn,
    input  wire cpa_pkg::cpa_pins_drv_s dut_oe,
    input  wire logic                   rival_req,
    input  wire logic                   take_back,
    input  wire logic [3:0]             rival_level,
    output cpa_pkg::cpa_pins_in_s       pins_in,
    output logic                        rival_won
);
    logic       gp_r, cmp_r, dflt_r, busy_r, rq_w, busy_w, eot_w, win_w;
    logic [3:0] cnt_r, stat_r, lane_r, bus;
    // ======================================================================
    // wired-low lines; a released line is pulled up to 1
    assign rq_w = rival_req & ~rival_won;
    assign bus = ~(dut_oe.priority_lines | lane_r);
    assign pins_in = {gp_r, ~(dut_oe.channel_request_n | rq_w),
        ~dut_oe.burst_n, ~(dut_oe.status0_n | (stat_r != 4'h0)),
        ~dut_oe.status1_n, ~dut_oe.cmd_n, bus};
    assign busy_w = ~&pins_in[7:4];
    assign eot_w = busy_r & ~busy_w;
    assign win_w = cmp_r & (bus == rival_level);
    // rival compares from the top line, drops lower lines on mismatch
    always_ff @(posedge core_clk)
    begin
        for (int i = 0; i < 4; i++)
            lane_r[i] <= cmp_r & gp_r & ~rival_level[i]
                & (((bus ^ rival_level) >> (i + 1)) == 4'h0);
    end
    // arbitrate on transfer end, on take_back, or on a request to the default master
    always_ff @(posedge core_clk)
    begin
        busy_r <= busy_w;
        stat_r <= (stat_r != 4'h0) ? stat_r - 4'h1 : 4'h0;
        if (!resetn)
        begin
            gp_r <= cpa_pkg::GP_GNT;
            {cnt_r, cmp_r, dflt_r, rival_won, stat_r} <= {4'h0, 3'b010, 4'h0};
        end
        else if (gp_r == cpa_pkg::GP_ARB)
        begin
            cnt_r <= cnt_r + 4'h1;
            // system master runs a short status cycle while arbitrating
            if (cnt_r == 4'h4)
                stat_r <= 4'h2;
            if (cnt_r == 4'hB)
            begin
                gp_r <= cpa_pkg::GP_GNT;
                rival_won <= win_w;
                dflt_r <= (bus == 4'hF);
                stat_r <= win_w ? 4'h3 : 4'h0;
            end
        end
        else if (eot_w | take_back
                 | (dflt_r & ~pins_in.channel_request_n))
        begin
            gp_r <= cpa_pkg::GP_ARB;
            cnt_r <= 4'h0;
            cmp_r <= rq_w;
            {dflt_r, rival_won} <= 2'b00;
        end
    end
endmodule : cpa_bus_model

/* File: test/tb_cpa_arbiter.sv */
// self-checking bench for the local arbiter against the bus model
`timescale 1ns/1ps
module tb_cpa_arbiter;
    logic core_clk = 1'b0, resetn = 1'b0, req = 1'b0, burst_mode = 1'b0;
    logic fairness_en = 1'b0, abort_first = 1'b0, xfer_go = 1'b0;
    logic xfer_last = 1'b0, rival_req = 1'b0, take_back = 1'b0;
    logic [3:0] arb_level = 4'h5, rival_level = 4'h3;
    logic arbitration_won, inactive, rival_won, xfer_busy, channel_request_n_seen;
    cpa_pkg::cpa_pins_in_s  pins_in;
    cpa_pkg::cpa_pins_drv_s pins_oe, pins_out;
    int miscompares = 0, n_compared = 0;
    cpa_arbiter u_cpa_arbiter (.core_clk(core_clk), .resetn(resetn),
        .req(req), .arb_level(arb_level), .burst_mode(burst_mode),
        .fairness_en(fairness_en), .abort_first(abort_first),
        .xfer_go(xfer_go), .xfer_last(xfer_last), .pins_in(pins_in),
        .pins_out(pins_out), .pins_oe(pins_oe),
        .arbitration_won(arbitration_won), .xfer_busy(xfer_busy),
        .inactive(inactive), .channel_request_n_seen(channel_request_n_seen));
    cpa_bus_model u_cpa_bus_model (.core_clk(core_clk), .resetn(resetn),
        .dut_oe(pins_oe), .rival_req(rival_req), .take_back(take_back),
        .rival_level(rival_level),
        .pins_in(pins_in), .rival_won(rival_won));
    // ======================================================================
    // clock and shared checks
    always #25 core_clk = ~core_clk;
    task chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("unexpected %s expected %h seen %h", what, exp, got);
            miscompares++;
        end
    endtask : chk
    task automatic wait_on(input int sel, input int lim);
        int n;
        n = 0;
        while (n < lim && !(sel == 0 ? arbitration_won === 1'b1 :
            sel == 1 ? rival_won === 1'b1 : sel == 2 ? inactive === 1'b1 :
            pins_oe.status0_n === 1'b1))
        begin
            @(posedge core_clk);
            #1 n++;
        end
        chk("wait", 4'h0, {3'b000, n >= lim});
    endtask : wait_on
    task run_last;  // one final cycle: status and latch, command, end
        @(posedge core_clk) {xfer_go, xfer_last} <= 2'b11;
        @(posedge core_clk) xfer_go <= 1'b0;
        #1 chk("stat", 4'hE, {pins_oe.status0_n, pins_oe.status1_n,
            pins_oe.address_latch_n, pins_oe.cmd_n});
        chk("busy", 4'h1, {3'b000, xfer_busy});
        repeat (2) @(posedge core_clk);
        #1 chk("cmd", 4'h1, {pins_oe.status0_n, pins_oe.status1_n,
            pins_oe.address_latch_n, pins_oe.cmd_n});
        repeat (4) @(posedge core_clk);
        #1 chk("gp", 4'h1, {3'b000, pins_in.grant_phase});
    endtask : run_last
    // ======================================================================
    // scenarios
    task t_single;
        @(posedge core_clk) req <= 1'b1;
        wait_on(0, 100);
        chk("req_oe", 4'h0, {pins_in.grant_phase, 2'b00,
            pins_oe.channel_request_n});
        chk("out", 4'h0, {3'b000, |pins_out});
        @(posedge core_clk) req <= 1'b0;
        run_last;
        $display("t_single done");
    endtask : t_single
    task t_lose;
        @(posedge core_clk) {req, rival_req, abort_first} <= 3'b111;
        wait_on(1, 100);
        chk("won", 4'h0, {3'b000, arbitration_won});
        @(posedge core_clk) rival_req <= 1'b0;
        wait_on(0, 100);
        wait_on(3, 8);
        chk("abort", 4'hC, {pins_oe.status0_n, pins_oe.status1_n,
            pins_oe.address_latch_n, pins_oe.cmd_n});
        @(posedge core_clk) {req, abort_first} <= 2'b00;
        repeat (30) @(posedge core_clk);
        $display("t_lose done");
    endtask : t_lose
    task t_channel_request_n;
        @(posedge core_clk) {req, burst_mode, fairness_en} <= 3'b111;
        wait_on(0, 100);
        chk("burst", 4'h1, {3'b000, pins_oe.burst_n});
        @(posedge core_clk) rival_req <= 1'b1;
        wait_on(2, 160);
        chk("parked", 4'h0, {1'b0, arbitration_won, pins_oe.burst_n,
            pins_oe.channel_request_n});
        chk("channel_request_n", 4'h1, {3'b000, channel_request_n_seen});
        wait_on(1, 100);
        @(posedge core_clk) rival_req <= 1'b0;
        wait_on(0, 200);
        chk("inactive", 4'h0, {3'b000, inactive});
        @(posedge core_clk) req <= 1'b0;
        run_last;
        $display("t_channel_request_n done");
    endtask : t_channel_request_n
    task t_takeback;  // control point takes a bursting owner's channel back
        @(posedge core_clk) req <= 1'b1;
        wait_on(0, 100);
        @(posedge core_clk) {req, take_back} <= 2'b01;
        @(posedge core_clk) take_back <= 1'b0;
        repeat (3) @(posedge core_clk);
        #1 chk("taken", 4'h0, {2'b00, arbitration_won,
            pins_oe.burst_n});
        $display("t_takeback done");
    endtask : t_takeback
    task results;
        $display("compared %0d miscompares %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : results
    initial
    begin
        repeat (20) @(posedge core_clk);
        resetn <= 1'b1;
        t_single;
        t_lose;
        t_channel_request_n;
        t_takeback;
        results;
    end
    initial
    begin
        #400000 miscompares++;
        results;
    end
endmodule : tb_cpa_arbiter
